// File: hdl/fsrs_ctrl.sv
// module: suspend/resume, software reset and parameter-space read logic of the flash
`timescale 1ns/1ps
module fsrs_ctrl
	import fsrs_pkg::*;
#(
	parameter int RECOV_IDLE_NS = 30000,
	parameter int RECOV_OP_NS   = 12000000
) (
	input  wire logic                clk,
	input  wire logic                reset_n,
	input  wire logic                sclk,
	input  wire logic                cs_n,
	input  wire logic [3:0]          io_in,
	output logic      [3:0]          io_out,
	output logic      [3:0]          io_oe_n,
	input  wire logic                quad_command_mode,
	input  wire logic                perf_enhance_mode,
	input  wire fsrs_op_t            op_req,
	input  wire logic                op_done,
	input  wire logic [SECTOR_W-1:0] read_sector,
	output logic                     read_region_invalid,
	output fsrs_status_t             status,
	output logic                     cmd_valid,
	output logic      [7:0]          cmd_opcode,
	output logic                     array_pause,
	output logic                     array_abort,
	output logic                     soft_reset
);
	localparam int REC_IDLE_CYC = (RECOV_IDLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int REC_OP_CYC   = (RECOV_OP_NS + CLK_NS - 1) / CLK_NS;
	localparam int REC_W        = $clog2(REC_OP_CYC + 1);

	// reset release
	logic [1:0] rst_pipe_ff;
	logic [1:0] nxt_rst_pipe;
	logic       rst_n_s;

	always_comb begin
		nxt_rst_pipe = {rst_pipe_ff[0], 1'b1};
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_pipe_ff <= 2'h0;
		end else begin
			rst_pipe_ff <= nxt_rst_pipe;
		end
	end

	assign rst_n_s = rst_pipe_ff[1];

	// link side, clocked by the host's serial clock
	fsrs_link_t              lk_ff;
	fsrs_link_t              nxt_lk;
	logic [LCNT_W-1:0]       cnt_ff;
	logic [LCNT_W-1:0]       nxt_cnt;
	logic [7:0]              sh_ff;
	logic [7:0]              nxt_sh;
	logic [ADDR_W-1:0]       addr_ff;
	logic [ADDR_W-1:0]       nxt_addr;
	logic [7:0]              dout_ff;
	logic [7:0]              nxt_dout;
	logic                    oe_n_ff;
	logic                    nxt_oe_n;
	logic [7:0]              hold_ff;
	logic [7:0]              nxt_hold;
	logic                    tgl_ff;
	logic                    nxt_tgl;
	logic                    quad_lk;
	logic [LCNT_W-1:0]       opc_last;

	// quad flag only moves while the serial clock runs
	fsrs_sync u_quad_sync (
		.clk   (sclk),
		.rst_n (rst_n_s),
		.d     (quad_command_mode),
		.q     (quad_lk)
	);

	always_comb begin
		nxt_lk   = lk_ff;
		nxt_cnt  = cnt_ff + LCNT_W'(1);
		nxt_addr = addr_ff;
		nxt_dout = dout_ff;
		nxt_oe_n = 1'b1;
		nxt_hold = hold_ff;
		nxt_tgl  = tgl_ff;
		opc_last = quad_lk ? LCNT_W'(QUAD_CLKS - 1) : LCNT_W'(SINGLE_CLKS - 1);
		// single-line mode looks at line 0 only
		nxt_sh   = quad_lk ? {sh_ff[3:0], io_in} : {sh_ff[6:0], io_in[0]};
		unique case (lk_ff)
			LK_OPC: begin
				if (cnt_ff == opc_last) begin
					nxt_hold = nxt_sh;
					nxt_tgl  = ~tgl_ff;
					nxt_cnt  = '0;
					nxt_lk   = (!quad_lk && nxt_sh == OP_PSR) ? LK_ADDR : LK_IDLE;
				end
			end
			LK_ADDR: begin
				nxt_addr = {addr_ff[ADDR_W-2:0], io_in[0]};
				if (cnt_ff == LCNT_W'(ADDR_CLKS - 1)) begin
					nxt_cnt = '0;
					nxt_lk  = LK_DUMMY;
				end
			end
			LK_DUMMY: begin
				if (cnt_ff == LCNT_W'(DUMMY_CLKS - 1)) begin
					nxt_cnt  = '0;
					nxt_lk   = LK_DATA;
					nxt_dout = fsrs_hdr_byte(addr_ff);
					nxt_oe_n = 1'b0;
				end
			end
			LK_DATA: begin
				// streams until the frame ends
				nxt_oe_n = 1'b0;
				if (cnt_ff == LCNT_W'(BYTE_BITS - 1)) begin
					nxt_cnt  = '0;
					nxt_addr = addr_ff + ADDR_W'(1);
					nxt_dout = fsrs_hdr_byte(addr_ff + ADDR_W'(1));
				end else begin
					nxt_dout = {dout_ff[6:0], 1'b0};
				end
			end
			LK_IDLE: begin
				nxt_cnt = cnt_ff;
			end
			default: begin
				nxt_lk = LK_IDLE;
			end
		endcase
	end

	// the frame's own select ends every link sequence
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			lk_ff   <= LK_OPC;
			cnt_ff  <= '0;
			sh_ff   <= 8'h00;
			addr_ff <= '0;
			dout_ff <= 8'h00;
			oe_n_ff <= 1'b1;
		end else begin
			lk_ff   <= nxt_lk;
			cnt_ff  <= nxt_cnt;
			sh_ff   <= nxt_sh;
			addr_ff <= nxt_addr;
			dout_ff <= nxt_dout;
			oe_n_ff <= nxt_oe_n;
		end
	end

	// opcode and its toggle outlive the frame for the crossing
	always_ff @(posedge sclk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			hold_ff <= 8'h00;
			tgl_ff  <= 1'b0;
		end else begin
			hold_ff <= nxt_hold;
			tgl_ff  <= nxt_tgl;
		end
	end

	assign io_out  = {2'b00, dout_ff[7], 1'b0};
	assign io_oe_n = {2'b11, oe_n_ff, 1'b1};

	// core side
	logic                cmd_lvl;
	logic                lvl_ff;
	logic                cmd_evt;
	fsrs_state_t         st_ff;
	fsrs_state_t         nxt_st;
	logic                wel_ff;
	logic                nxt_wel;
	logic                arm_ff;
	logic                nxt_arm;
	logic [EL_W-1:0]     el_ff;
	logic [EL_W-1:0]     nxt_el;
	logic                kind_ff;
	logic                nxt_kind;
	logic [SECTOR_W-1:0] sec_ff;
	logic [SECTOR_W-1:0] nxt_sec;
	logic [REC_W-1:0]    rc_ff;
	logic [REC_W-1:0]    nxt_rc;
	fsrs_status_t        stat_ff;
	fsrs_status_t        nxt_stat;
	logic                cmdv_ff;
	logic                nxt_cmdv;
	logic [7:0]          cmdop_ff;
	logic [7:0]          nxt_cmdop;
	logic                abort_ff;
	logic                nxt_abort;
	logic                srst_ff;
	logic                nxt_srst;
	logic                inv_ff;
	logic                nxt_inv;
	logic                susp;
	logic                active;
	logic                take;
	logic                nsusp;

	fsrs_sync u_cmd_sync (
		.clk   (clk),
		.rst_n (rst_n_s),
		.d     (tgl_ff),
		.q     (cmd_lvl)
	);

	// hold_ff settled many cycles before the toggle shows here
	assign cmd_evt = cmd_lvl ^ lvl_ff;

	always_comb begin
		nxt_st    = st_ff;
		nxt_wel   = wel_ff;
		nxt_arm   = arm_ff;
		nxt_el    = el_ff;
		nxt_kind  = kind_ff;
		nxt_sec   = sec_ff;
		nxt_rc    = rc_ff;
		nxt_cmdv  = 1'b0;
		nxt_cmdop = cmdop_ff;
		nxt_abort = 1'b0;
		nxt_srst  = 1'b0;
		susp      = (st_ff == ST_PROG_SUSP) || (st_ff == ST_ERASE_SUSP);
		active    = susp || (st_ff == ST_PROG) || (st_ff == ST_ERASE) || (st_ff == ST_SUSP_WAIT);
		// outside the accepted set nothing moves
		take      = cmd_evt && (st_ff != ST_RECOV) && (!susp || fsrs_susp_ok(hold_ff));
		if (kind_ff && el_ff != EL_W'(ERASE_MIN_CYC) &&
				(st_ff == ST_ERASE || st_ff == ST_SUSP_WAIT)) begin
			nxt_el = el_ff + EL_W'(1);
		end
		unique case (st_ff)
			ST_IDLE: begin
				if (op_req.start && wel_ff) begin
					nxt_st   = op_req.erase ? ST_ERASE : ST_PROG;
					nxt_kind = op_req.erase;
					nxt_sec  = op_req.sector;
					nxt_el   = '0;
					nxt_wel  = 1'b0;
				end
			end
			ST_PROG, ST_ERASE: begin
				if (op_done) begin
					nxt_st = ST_IDLE;
				end
			end
			ST_SUSP_WAIT: begin
				if (op_done) begin
					nxt_st = ST_IDLE;
				end else if (!kind_ff || el_ff == EL_W'(ERASE_MIN_CYC)) begin
					nxt_st  = kind_ff ? ST_ERASE_SUSP : ST_PROG_SUSP;
					nxt_wel = 1'b0;
				end
			end
			ST_PROG_SUSP, ST_ERASE_SUSP: begin
				nxt_st = st_ff;
			end
			ST_RECOV: begin
				if (rc_ff == '0) begin
					nxt_st = ST_IDLE;
				end else begin
					nxt_rc = rc_ff - REC_W'(1);
				end
			end
			default: begin
				nxt_st = ST_IDLE;
			end
		endcase
		if (take) begin
			nxt_cmdv  = 1'b1;
			nxt_cmdop = hold_ff;
			// any other command disarms
			nxt_arm   = (hold_ff == OP_RST_ARM);
			case (hold_ff)
				OP_WRITE_ENABLE_CMD: nxt_wel = 1'b1;
				OP_WRDI: nxt_wel = 1'b0;
				OP_SUSPEND: begin
					if (st_ff == ST_PROG || st_ff == ST_ERASE) begin
						nxt_st = ST_SUSP_WAIT;
					end
				end
				OP_RESUME: begin
					// no write enable needed
					if (susp && !perf_enhance_mode) begin
						nxt_st = kind_ff ? ST_ERASE : ST_PROG;
					end
				end
				OP_RESET: begin
					if (arm_ff) begin
						nxt_st    = ST_RECOV;
						nxt_rc    = active ? REC_W'(REC_OP_CYC) : REC_W'(REC_IDLE_CYC);
						nxt_abort = active;
						nxt_srst  = 1'b1;
						nxt_wel   = 1'b0;
						nxt_el    = '0;
						nxt_kind  = 1'b0;
					end
				end
				default: ;
			endcase
		end
		nsusp                         = (nxt_st == ST_PROG_SUSP) || (nxt_st == ST_ERASE_SUSP);
		nxt_stat.busy                 = (nxt_st != ST_IDLE) && !nsusp;
		nxt_stat.ready                = (nxt_st != ST_RECOV);
		nxt_stat.write_enable_latch   = nxt_wel;
		nxt_stat.program_suspend_flag = (nxt_st == ST_PROG_SUSP);
		nxt_stat.erase_suspend_flag   = (nxt_st == ST_ERASE_SUSP);
		nxt_inv                       = nsusp && (read_sector == nxt_sec);
	end

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			lvl_ff   <= 1'b0;
			st_ff    <= ST_IDLE;
			wel_ff   <= 1'b0;
			arm_ff   <= 1'b0;
			el_ff    <= '0;
			kind_ff  <= 1'b0;
			sec_ff   <= '0;
			rc_ff    <= '0;
			stat_ff  <= '{busy: 1'b0, ready: 1'b1, default: 1'b0};
			cmdv_ff  <= 1'b0;
			cmdop_ff <= 8'h00;
			abort_ff <= 1'b0;
			srst_ff  <= 1'b0;
			inv_ff   <= 1'b0;
		end else begin
			lvl_ff   <= cmd_lvl;
			st_ff    <= nxt_st;
			wel_ff   <= nxt_wel;
			arm_ff   <= nxt_arm;
			el_ff    <= nxt_el;
			kind_ff  <= nxt_kind;
			sec_ff   <= nxt_sec;
			rc_ff    <= nxt_rc;
			stat_ff  <= nxt_stat;
			cmdv_ff  <= nxt_cmdv;
			cmdop_ff <= nxt_cmdop;
			abort_ff <= nxt_abort;
			srst_ff  <= nxt_srst;
			inv_ff   <= nxt_inv;
		end
	end

	assign status              = stat_ff;
	assign cmd_valid           = cmdv_ff;
	assign cmd_opcode          = cmdop_ff;
	assign array_abort         = abort_ff;
	assign soft_reset          = srst_ff;
	assign read_region_invalid = inv_ff;
	assign array_pause         = stat_ff.program_suspend_flag || stat_ff.erase_suspend_flag;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n_s);

	logic susp_req;
	logic res_req;
	logic rst_req;
	assign susp_req = take && hold_ff == OP_SUSPEND && (st_ff == ST_PROG || st_ff == ST_ERASE);
	assign res_req  = take && hold_ff == OP_RESUME && susp && !perf_enhance_mode;
	assign rst_req  = take && hold_ff == OP_RESET && arm_ff;

	// wait is too long for a delay range, so it is counted here
	logic [EL_W-1:0] swc_ff;
	logic [EL_W-1:0] nxt_swc;

	always_comb begin
		nxt_swc = '0;
		if (st_ff == ST_SUSP_WAIT) begin
			nxt_swc = (swc_ff == '1) ? swc_ff : swc_ff + EL_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			swc_ff <= '0;
		end else begin
			swc_ff <= nxt_swc;
		end
	end

	sequence s_susp_req;
		susp_req;
	endsequence
	sequence s_susp_wait;
		st_ff == ST_SUSP_WAIT;
	endsequence

	property p_susp_latency;
		s_susp_req |=> s_susp_wait;
	endproperty
	a_susp_latency: assert property (p_susp_latency) else $error("suspend not entered");

	property p_susp_bound;
		s_susp_wait |-> swc_ff < EL_W'(SUSP_READY_CYC);
	endproperty
	a_susp_bound: assert property (p_susp_bound) else $error("suspend not ready in time");

	property p_erase_min;
		$rose(stat_ff.erase_suspend_flag) && !$past(res_req) |-> el_ff == EL_W'(ERASE_MIN_CYC);
	endproperty
	a_erase_min: assert property (p_erase_min) else $error("erase suspended too early");

	property p_wel_clear;
		$rose(array_pause) |-> !stat_ff.write_enable_latch;
	endproperty
	a_wel_clear: assert property (p_wel_clear) else $error("latch set on suspend");

	property p_resume;
		res_req |=> !array_pause && stat_ff.busy;
	endproperty
	a_resume: assert property (p_resume) else $error("resume did not clear flag");

	property p_perf;
		array_pause && perf_enhance_mode && !rst_req |=> array_pause;
	endproperty
	a_perf: assert property (p_perf) else $error("resumed in enhance mode");

	property p_nop;
		take && hold_ff == OP_NOP |=> !arm_ff ##1 !srst_ff;
	endproperty
	a_nop: assert property (p_nop) else $error("no-operation left reset armed");

	property p_reset_armed;
		$rose(srst_ff) |-> $past(arm_ff) && $past(cmd_evt);
	endproperty
	a_reset_armed: assert property (p_reset_armed) else $error("reset without arm");

	property p_reset_default;
		srst_ff |-> !stat_ff.write_enable_latch && !array_pause && !arm_ff && !stat_ff.ready;
	endproperty
	a_reset_default: assert property (p_reset_default) else $error("reset left state");

	property p_abort;
		rst_req && active |=> abort_ff && srst_ff;
	endproperty
	a_abort: assert property (p_abort) else $error("operation not aborted");

	property p_ignore;
		cmd_evt && susp && !fsrs_susp_ok(hold_ff) |=> $stable(st_ff) && $stable(wel_ff) && !cmdv_ff;
	endproperty
	a_ignore: assert property (p_ignore) else $error("disallowed command acted");

endmodule // fsrs_ctrl

// File: hdl/fsrs_pkg.sv
// package: opcodes, timing, parameter header and carrier types of the flash command block
// Summary of operation
// - running erase or program can be suspended
// - suspended-ready within 20us of suspend
// - opcodes in 8 single or 2 quad clocks
// - suspended region reads flagged invalid
// - erase suspend clears latch, limits commands
// - erase suspend waits 20us after start
// - suspend flags set, cleared on resume
// - program suspend clears latch, limits commands
// - resume opcode 30h needs no write enable
// - busy shown again after resume
// - resume ignored during performance enhance mode
// - no-operation only cancels armed reset
// - reset only directly after reset arm
// - reset restores volatile power-on defaults
// - reset aborts operation, recovery time varies
// - 5Ah, 3 address, 1 dummy, data out
// - header count byte 06h holds 01h
// - first header: 00h, 1.0, 09h, 30h
// - second header bytes 10h-17h: 04h, 60h
package fsrs_pkg;

	localparam logic [7:0] OP_SUSPEND = 8'hB0;
	localparam logic [7:0] OP_RESUME  = 8'h30;
	localparam logic [7:0] OP_NOP     = 8'h00;
	localparam logic [7:0] OP_RST_ARM = 8'h66;
	localparam logic [7:0] OP_RESET   = 8'h99;
	localparam logic [7:0] OP_WRITE_ENABLE_CMD    = 8'h06;
	localparam logic [7:0] OP_WRDI    = 8'h04;
	localparam logic [7:0] OP_PSR     = 8'h5A;

	localparam int CLK_NS         = 20;
	localparam int SUSP_READY_NS  = 20000;
	localparam int SUSP_READY_CYC = SUSP_READY_NS / CLK_NS;
	localparam int ERASE_MIN_NS   = 20000;
	localparam int ERASE_MIN_CYC  = (ERASE_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int RESUME_GAP_NS  = 1000000;
	localparam int EL_W           = $clog2(ERASE_MIN_CYC + 1);

	localparam int SINGLE_CLKS = 8;
	localparam int QUAD_CLKS   = 2;
	localparam int ADDR_CLKS   = 24;
	localparam int DUMMY_CLKS  = 8;
	localparam int BYTE_BITS   = 8;
	localparam int LCNT_W      = 5;
	localparam int ADDR_W      = 24;
	localparam int SECTOR_W    = 12;

	// arbitrary neutral value, not any maker's code
	localparam logic [7:0] VENDOR_ID = 8'h5A;
	localparam logic [7:0] HDR_FILL  = 8'hFF;
	localparam int         HDR_BYTES = 24;
	localparam logic [7:0] HDR_ROM [0:HDR_BYTES-1] = '{
		8'h53, 8'h46, 8'h44, 8'h50,  // signature
		8'h00, 8'h01, 8'h01, 8'hFF,  // revision 1.0, two headers
		8'h00, 8'h00, 8'h01, 8'h09,  // first header
		8'h30, 8'h00, 8'h00, 8'hFF,
		VENDOR_ID, 8'h00, 8'h01, 8'h04,  // second header
		8'h60, 8'h00, 8'h00, 8'hFF
	};

	typedef enum logic [2:0] {
		ST_IDLE       = 3'b000,
		ST_PROG       = 3'b001,
		ST_ERASE      = 3'b010,
		ST_SUSP_WAIT  = 3'b011,
		ST_PROG_SUSP  = 3'b100,
		ST_ERASE_SUSP = 3'b101,
		ST_RECOV      = 3'b110
	} fsrs_state_t;

	typedef enum logic [2:0] {
		LK_OPC   = 3'b000,
		LK_ADDR  = 3'b001,
		LK_DUMMY = 3'b010,
		LK_DATA  = 3'b011,
		LK_IDLE  = 3'b100
	} fsrs_link_t;

	typedef struct packed {
		logic busy;
		logic ready;
		logic write_enable_latch;
		logic program_suspend_flag;
		logic erase_suspend_flag;
	} fsrs_status_t;

	typedef struct packed {
		logic                start;
		logic                erase;
		logic [SECTOR_W-1:0] sector;
	} fsrs_op_t;

	function automatic logic [7:0] fsrs_hdr_byte(input logic [ADDR_W-1:0] a);
		fsrs_hdr_byte = (a < ADDR_W'(HDR_BYTES)) ? HDR_ROM[a[LCNT_W-1:0]] : HDR_FILL;
	endfunction

	// commands still taken while suspended
	function automatic logic fsrs_susp_ok(input logic [7:0] op);
		case (op)
			8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB, 8'h5A, 8'hC0,
			8'h06, 8'h04, 8'h2B, 8'h9F, 8'hAF, 8'h05, 8'hAB, 8'h90,
			8'hB1, 8'hC1, 8'hB0, 8'h30, 8'h66, 8'h99, 8'h00, 8'h35,
			8'hF5, 8'h15, 8'h2D, 8'h27, 8'hA7, 8'hE2, 8'hE0, 8'h16: fsrs_susp_ok = 1'b1;
			default: fsrs_susp_ok = 1'b0;
		endcase
	endfunction

endpackage

// File: hdl/fsrs_sync.sv
// module: three-stage synchroniser whose output moves once stages two and three agree
`timescale 1ns/1ps
module fsrs_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic d,
	output logic      q
);
	logic [2:0] stg_ff;
	logic [2:0] nxt_stg;
	logic       q_ff;
	logic       nxt_q;

	always_comb begin
		nxt_stg = {stg_ff[1:0], d};
		nxt_q   = (stg_ff[1] == stg_ff[2]) ? stg_ff[2] : q_ff;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stg_ff <= 3'h0;
			q_ff   <= 1'b0;
		end else begin
			stg_ff <= nxt_stg;
			q_ff   <= nxt_q;
		end
	end

	assign q = q_ff;
endmodule // fsrs_sync

// File: sim/fsrs_ctrl_tb_top.sv
// self-checking bench of the flash suspend, reset and parameter read block
`timescale 1ns/1ps
module fsrs_ctrl_tb_top
	import fsrs_pkg::*;
;
	logic                clk = 1'b0;
	logic                reset_n = 1'b0;
	logic                quad = 1'b0;
	logic                perf = 1'b0;
	logic                op_done = 1'b0;
	fsrs_op_t            op_req = '0;
	logic [SECTOR_W-1:0] rsec = '0;
	wire                 sclk;
	wire                 cs_n;
	wire  [3:0]          io_in;
	wire  [3:0]          io_out;
	wire  [3:0]          io_oe_n;
	logic                inv;
	fsrs_status_t        st;
	logic                cv;
	logic                ab;
	logic                sr;
	logic                pause;
	logic [7:0]          cop;
	int                  error_cnt = 0;
	int                  check_count = 0;
	int                  n_cv = 0;
	int                  n_sr = 0;
	int                  n_ab = 0;
	int                  rc = 0;

	localparam int RECOV_OP_NS_TB   = 2000;
	localparam int RECOV_IDLE_NS_TB = 1000;

	always #10 clk = ~clk;

	fsrs_host i_host (.sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
		.io_oe_n(io_oe_n));
	fsrs_ctrl #(.RECOV_IDLE_NS(RECOV_IDLE_NS_TB), .RECOV_OP_NS(RECOV_OP_NS_TB)) i_dut (
		.clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
		.io_out(io_out), .io_oe_n(io_oe_n), .quad_command_mode(quad),
		.perf_enhance_mode(perf), .op_req(op_req), .op_done(op_done), .read_sector(rsec),
		.read_region_invalid(inv), .status(st), .cmd_valid(cv), .cmd_opcode(cop),
		.array_pause(pause), .array_abort(ab), .soft_reset(sr));

	// pulse counters and length of the last ready-low stretch
	always @(posedge clk) begin
		if (cv === 1'b1)
			n_cv <= n_cv + 1;
		if (sr === 1'b1)
			n_sr <= n_sr + 1;
		if (ab === 1'b1)
			n_ab <= n_ab + 1;
		if (sr === 1'b1)
			rc <= 0;
		else if (st.ready === 1'b0)
			rc <= rc + 1;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic start_op(input logic er, input logic [SECTOR_W-1:0] sec);
		i_host.frame(OP_WRITE_ENABLE_CMD, 1'b0);
		@(negedge clk) op_req = '{1'b1, er, sec};
		@(negedge clk) op_req.start = 1'b0;
	endtask

	task automatic wait_ready(input int exp_low);
		for (int t = 0; t < 400 && st.ready !== 1'b1; t++)
			@(negedge clk);
		chk("recovery", (rc >= exp_low - 2) && (rc <= exp_low + 2), 1);
		chk("defaults", st, 5'b01000);
	endtask

	task automatic t_reset();
		chk("reset_status", st, 5'b01000);
		chk("reset_oe", io_oe_n, 4'hF);
		$display("test reset values done");
	endtask

	task automatic t_erase();
		int c;
		start_op(1'b1, 12'h0A5);
		i_host.frame(OP_SUSPEND, 1'b0);
		repeat (850) @(negedge clk);
		chk("esb_early", st.erase_suspend_flag, 0);
		for (int t = 0; t < 150 && st.erase_suspend_flag !== 1'b1; t++)
			@(negedge clk);
		chk("esb_set", st.erase_suspend_flag, 1);
		chk("esb_state", {st.busy, st.write_enable_latch, pause}, 3'b001);
		c = n_cv;
		i_host.frame(8'h02, 1'b0);
		chk("refused", n_cv - c, 0);
		chk("still_susp", st.erase_suspend_flag, 1);
		i_host.frame(8'h03, 1'b0);
		chk("read_taken", n_cv - c, 1);
		i_host.frame(OP_RST_ARM, 1'b0);
		i_host.frame(OP_RESET, 1'b0);
		chk("abort", {16'(n_sr), 16'(n_ab)}, 32'h0001_0001);
		wait_ready(RECOV_OP_NS_TB / CLK_NS);
		$display("test erase suspend and reset done");
	endtask

	task automatic t_arm();
		i_host.frame(OP_WRITE_ENABLE_CMD, 1'b0);
		i_host.frame(OP_RST_ARM, 1'b0);
		i_host.frame(OP_NOP, 1'b0);
		chk("nop_keeps", st.write_enable_latch, 1);
		i_host.frame(OP_RESET, 1'b0);
		chk("nop_cancel", n_sr, 1);
		i_host.frame(OP_RST_ARM, 1'b0);
		i_host.frame(OP_WRDI, 1'b0);
		i_host.frame(OP_RESET, 1'b0);
		chk("other_cancel", n_sr, 1);
		i_host.frame(OP_RST_ARM, 1'b0);
		i_host.frame(OP_RESET, 1'b0);
		chk("idle_reset", {16'(n_sr), 16'(n_ab)}, 32'h0002_0001);
		wait_ready(RECOV_IDLE_NS_TB / CLK_NS);
		$display("test reset arming done");
	endtask

	task automatic t_param();
		logic [7:0] q[$];
		logic [7:0] e [0:25] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hFF,
			8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF, VENDOR_ID, 8'h00,
			8'h01, 8'h04, 8'h60, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF};
		i_host.rd_param(24'h000000, 26, q);
		for (int i = 0; i < 26; i++)
			chk("header", q[i], e[i]);
		q.delete();
		i_host.rd_param(24'h000013, 2, q);
		chk("mid_start", {q[0], q[1]}, 16'h0460);
		chk("oe_off", io_oe_n, 4'hF);
		$display("test parameter read done");
	endtask

	task automatic t_prog();
		int c;
		start_op(1'b0, 12'h123);
		chk("busy", {st.busy, st.write_enable_latch}, 2'b10);
		i_host.frame(OP_WRITE_ENABLE_CMD, 1'b0);
		i_host.frame(OP_SUSPEND, 1'b0);
		chk("psb", {st.program_suspend_flag, st.erase_suspend_flag, pause}, 3'b101);
		chk("psb_state", {st.busy, st.write_enable_latch}, 2'b00);
		@(negedge clk) rsec = 12'h123;
		repeat (3) @(negedge clk);
		chk("region_bad", inv, 1);
		@(negedge clk) rsec = 12'h124;
		repeat (3) @(negedge clk);
		chk("region_ok", inv, 0);
		@(negedge clk) perf = 1'b1;
		c = n_cv;
		i_host.frame(OP_RESUME, 1'b0);
		chk("perf_block", n_cv - c, 1);
		chk("perf_held", st.program_suspend_flag, 1);
		@(negedge clk) perf = 1'b0;
		@(negedge clk) quad = 1'b1;
		repeat (3) i_host.frame(OP_NOP, 1'b1);
		i_host.frame(OP_RESUME, 1'b1);
		chk("quad_op", cop, OP_RESUME);
		chk("resumed", {st.program_suspend_flag, st.busy}, 2'b01);
		@(negedge clk) op_done = 1'b1;
		@(negedge clk) op_done = 1'b0;
		repeat (2) @(negedge clk);
		chk("done", {st.busy, st.ready}, 2'b01);
		$display("test program suspend done");
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#500us;
		error_cnt++;
		print_verdict();
	end

	initial begin
		repeat (10) @(negedge clk);
		reset_n = 1'b1;
		repeat (5) @(negedge clk);
		t_reset();
		t_erase();
		t_arm();
		t_param();
		t_prog();
		print_verdict();
	end
endmodule // fsrs_ctrl_tb_top

// File: sim/fsrs_host.sv
// host flash controller model: opcode frames and parameter-space reads on the link
`timescale 1ns/1ps
module fsrs_host
	import fsrs_pkg::*;
(
	output logic            sclk,
	output logic            cs_n,
	output logic      [3:0] io_in,
	input  wire logic [3:0] io_out,
	input  wire logic [3:0] io_oe_n
);
	realtime t_res = -1.0e7;
	// a real rising select clears the link logic at start
	initial begin
		sclk = 1'b0;
		cs_n = 1'b0;
		io_in = 4'h5;
		#1 cs_n = 1'b1;
	end
	// link clock only runs inside frames
	task automatic pulse();
		#32 sclk = 1'b1;
		#32 sclk = 1'b0;
	endtask
	// upper lines toggle in single mode, they must be ignored
	task automatic shift(input logic [7:0] b, input bit quad);
		for (int i = 7; i >= 0; i -= (quad ? 4 : 1)) begin
			if (quad)
				io_in = b[i-:4];
			else
				io_in = {~io_in[3:1], b[i]};
			pulse();
		end
	endtask
	task automatic frame(input logic [7:0] op, input bit quad);
		while (op == OP_SUSPEND && $realtime - t_res < real'(RESUME_GAP_NS))
			#100;
		cs_n = 1'b0;
		shift(op, quad); // one opcode then deselect
		cs_n = 1'b1;
		io_in = ~io_in; // released lines never keep a stale level
		if (op == OP_RESUME)
			t_res = $realtime;
		#512;
	endtask
	task automatic rd_param(input logic [23:0] a, input int n, ref logic [7:0] q[$]);
		logic [7:0] b;
		cs_n = 1'b0;
		shift(OP_PSR, 1'b0); // opcode, address, dummy
		for (int k = 2; k >= 0; k--)
			shift(a[8*k+:8], 1'b0);
		shift(8'hA5, 1'b0);
		repeat (n) begin
			for (int i = 0; i < 8; i++) begin
				b = {b[6:0], io_out[1]};
				io_in = ~io_in;
				pulse();
			end
			q.push_back(b);
		end
		cs_n = 1'b1;
		#512;
	endtask
endmodule // fsrs_host
